/* File: rtl/cs_sense_top.sv */
// capacitive sense frequency counter: control register, clock routing to two timers, gate logic.
// assumes a synchronous register port on i_clock and an asynchronous oscillator comparator pin.
//
// Behaviour
// (RL1) sense oscillator clocks first or second timer
// (RL2) software divides count by window length
// (RL3) window timed by the other timer
// (RL4) select set, source cleared: first timer senses
// (RL5) second timer source 11 takes oscillator
// (RL6) on/gate-enable bits: off, free, gated
// (RL7) software gates via overflow and toggle mode
// (RL8) baseline: clear at start, capture at end
// (RL9) loaded run same window, lower count
// (RL10) threshold midway between baseline and loaded
// (RL11) oscillator runs through sleep while enabled
// (RL12) counting in sleep, evaluation needs wake
// (RL13) first timer halts during sleep
// (RL14) enable cleared: no channel, sensing off
// (RL15) range bit picks external or internal references
// (RL16) high range 00 is noise mode
// (RL17) status bit shows sourcing or sinking
// (RL18) each oscillator cycle counts exactly once
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module cs_sense_top (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  // processor state
  input wire logic i_sleep,
  // pins from the analog side
  input wire logic i_osc_pin,
  input wire logic i_gate_pin,
  // controls to the analog side
  output logic o_channel_enable,
  output logic o_reference_high,
  output logic [1:0] o_current_range,
  output logic o_osc_active,
  output logic o_current_drive
);
  cs_count_if t0 ();
  cs_count_if t1 ();

  logic [7:0] sc_r;
  logic t0_cs_r;
  logic [7:0] t1c_r;
  logic t0_ovf_flag_r;
  logic gate_tog_r;
  logic [1:0] div_r;
  logic [7:0] rd_data_r;
  logic ch_en_r;
  logic ref_hi_r;
  logic [1:0] cur_r;
  logic osc_act_r;
  logic drive_r;
  logic osc_level;
  logic osc_rise;
  logic gate_level;

  // input synchronisers
  cs_sync u_osc_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async(i_osc_pin),
    .o_level(osc_level),
    .o_rise(osc_rise)
  );
  cs_sync u_gate_sync (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .i_async(i_gate_pin),
    .o_level(gate_level),
    .o_rise()
  );

  // the two timers
  cs_counter #(.WRAP(cs_pkg::FIRST_TIMER_WRAP)) u_first_timer (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .cnt(t0.cnt)
  );
  cs_counter #(.WRAP(cs_pkg::SECOND_TIMER_WRAP)) u_second_timer (
    .i_clock(i_clock),
    .i_srst(i_srst),
    .cnt(t1.cnt)
  );

  // field decode
  wire sense_en = sc_r[cs_pkg::SENSE_UNIT_ENABLE_BIT];
  wire range_hi = sc_r[cs_pkg::REFERENCE_RANGE_SELECT_BIT];
  wire [1:0] cur_range = sc_r[cs_pkg::CURRENT_RANGE_LSB +: 2];
  wire t0_sense_sel = sc_r[cs_pkg::FIRST_TIMER_SENSE_CLOCK_SELECT_BIT];
  wire t1_on = t1c_r[cs_pkg::SECOND_TIMER_ON_BIT];
  wire t1_ge = t1c_r[cs_pkg::SECOND_TIMER_GATE_ENABLE_BIT];
  wire gate_tog_mode = t1c_r[cs_pkg::GATE_TOGGLE_MODE_BIT];
  wire gate_pol = t1c_r[cs_pkg::GATE_POLARITY_BIT];
  wire [1:0] t1_src = t1c_r[cs_pkg::SECOND_TIMER_CLOCK_SOURCE_LSB +: 2];

  // address decode
  wire wr_sc = i_wr & (i_addr == cs_pkg::SENSE_CONTROL_OFS);
  wire wr_t0cfg = i_wr & (i_addr == cs_pkg::FIRST_TIMER_CFG_OFS);
  wire wr_t0cnt = i_wr & (i_addr == cs_pkg::FIRST_TIMER_CNT_OFS);
  wire wr_t1c = i_wr & (i_addr == cs_pkg::SECOND_TIMER_CONTROL_OFS);
  wire wr_t1lo = i_wr & (i_addr == cs_pkg::SECOND_TIMER_LO_OFS);
  wire wr_t1hi = i_wr & (i_addr == cs_pkg::SECOND_TIMER_HI_OFS);
  wire wr_stat = i_wr & (i_addr == cs_pkg::SENSE_STATUS_OFS);

  // oscillator state seen by the timers and the status bit
  wire osc_running = sense_en & (range_hi | (cur_range != cs_pkg::CURRENT_RANGE_IDLE)); // [RL11] [RL16]
  wire osc_tick = osc_rise & osc_running; // one pulse per cycle [RL18]
  wire osc_dir = osc_level & osc_running; // high while sourcing [RL17]
  wire instr_tick = (div_r == cs_pkg::INSTR_DIV_LAST);

  // first timer clock: oscillator or instruction tick, frozen in sleep
  wire t0_from_osc = t0_sense_sel & ~t0_cs_r; // [RL1] [RL4]
  wire t0_src_tick = t0_from_osc ? osc_tick : (~t0_cs_r & instr_tick);
  assign t0.inc = t0_src_tick & ~i_sleep; // [RL13]
  assign t0.load = wr_t0cnt;
  assign t0.load_val = {8'h00, i_wr_data};

  // second timer gate: pin level or toggled by first timer overflow
  wire gate_raw = gate_tog_mode ? gate_tog_r : gate_level;
  wire gate_open = gate_raw ^ gate_pol;

  // second timer clock source; only the oscillator keeps it counting in sleep
  logic t1_src_tick;
  always_comb begin
    unique case (cs_pkg::cs_clock_source_type'(t1_src))
      cs_pkg::CS_SRC_INSTR: t1_src_tick = instr_tick & ~i_sleep;
      cs_pkg::CS_SRC_SYSTEM: t1_src_tick = ~i_sleep;
      cs_pkg::CS_SRC_EXTERNAL: t1_src_tick = 1'b0;
      cs_pkg::CS_SRC_SENSE_OSC: t1_src_tick = osc_tick; // [RL1] [RL5] [RL12]
    endcase
  end
  assign t1.inc = t1_src_tick & t1_on & (~t1_ge | gate_open); // [RL6]
  assign t1.load = wr_t1lo | wr_t1hi;
  assign t1.load_val = wr_t1hi ? {i_wr_data, t1.count[7:0]} : {t1.count[15:8], i_wr_data};

  // analog controls, registered
  wire ch_en_nxt = sense_en; // [RL14]
  wire ref_hi_nxt = sense_en & range_hi; // [RL15]
  wire drive_nxt = sense_en & (cur_range != cs_pkg::CURRENT_RANGE_IDLE); // [RL16]

  // read mux
  logic [7:0] rd_nxt;
  always_comb begin
    rd_nxt = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        cs_pkg::SENSE_CONTROL_OFS: rd_nxt = {sc_r[7:6], 2'b00, sc_r[3:2], osc_dir, sc_r[0]}; // [RL17]
        cs_pkg::FIRST_TIMER_CFG_OFS: rd_nxt = {7'h00, t0_cs_r};
        cs_pkg::FIRST_TIMER_CNT_OFS: rd_nxt = t0.count[7:0];
        cs_pkg::SECOND_TIMER_CONTROL_OFS: rd_nxt = {2'b00, t1c_r[5:0]};
        cs_pkg::SECOND_TIMER_LO_OFS: rd_nxt = t1.count[7:0];
        cs_pkg::SECOND_TIMER_HI_OFS: rd_nxt = t1.count[15:8];
        cs_pkg::SENSE_STATUS_OFS: rd_nxt = {6'h00, gate_open, t0_ovf_flag_r};
        default: rd_nxt = 8'h00;
      endcase
    end
  end

  // control registers
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sc_r <= cs_pkg::SENSE_CONTROL_RESET;
      t0_cs_r <= 1'b1;
      t1c_r <= cs_pkg::SECOND_TIMER_CONTROL_RESET;
    end else begin
      if (wr_sc) sc_r <= {i_wr_data[7:6], 2'b00, i_wr_data[3:2], 1'b0, i_wr_data[0]};
      if (wr_t0cfg) t0_cs_r <= i_wr_data[cs_pkg::FIRST_TIMER_CLOCK_SOURCE_BIT];
      if (wr_t1c) t1c_r <= {2'b00, i_wr_data[5:0]};
    end
  end

  // overflow flag: set wins over a clearing write; toggle gate flips on overflow
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      t0_ovf_flag_r <= 1'b0;
      gate_tog_r <= 1'b0;
    end else begin
      t0_ovf_flag_r <= t0.ovf | (t0_ovf_flag_r & ~(wr_stat & ~i_wr_data[cs_pkg::FIRST_TIMER_OVERFLOW_BIT]));
      gate_tog_r <= gate_tog_mode ? (gate_tog_r ^ t0.ovf) : 1'b0;
    end
  end

  // instruction divider, read data and analog outputs
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      div_r <= 2'b00;
      rd_data_r <= 8'h00;
      ch_en_r <= 1'b0;
      ref_hi_r <= 1'b0;
      cur_r <= 2'b00;
      osc_act_r <= 1'b0;
      drive_r <= 1'b0;
    end else begin
      div_r <= instr_tick ? 2'b00 : 2'(div_r + 2'b01);
      rd_data_r <= rd_nxt;
      ch_en_r <= ch_en_nxt;
      ref_hi_r <= ref_hi_nxt;
      cur_r <= sense_en ? cur_range : 2'b00;
      osc_act_r <= osc_running; // not gated by sleep [RL11]
      drive_r <= drive_nxt;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_channel_enable = ch_en_r;
  assign o_reference_high = ref_hi_r;
  assign o_current_range = cur_r;
  assign o_osc_active = osc_act_r;
  assign o_current_drive = drive_r;

  // first timer advances by one on an oscillator edge when routed to it
  chk_first_osc_count: assert property ( // [RL4]
    @(posedge i_clock) disable iff (i_srst)
    (t0_from_osc && osc_tick && !i_sleep && !t0.load && t0.count != cs_pkg::FIRST_TIMER_WRAP)
    |=> t0.count == 16'($past(t0.count) + 16'h0001))
    else $error("first timer missed an oscillator edge");

  // second timer on source 11 advances on an oscillator edge, asleep or not
  chk_second_osc_count: assert property ( // [RL5]
    @(posedge i_clock) disable iff (i_srst)
    (t1_src == 2'b11 && t1_on && !t1_ge && osc_tick && !t1.load && t1.count != cs_pkg::SECOND_TIMER_WRAP)
    |=> t1.count == 16'($past(t1.count) + 16'h0001))
    else $error("second timer missed an oscillator edge");

  // second timer holds while off
  chk_second_off_hold: assert property ( // [RL6]
    @(posedge i_clock) disable iff (i_srst)
    (!t1_on && !t1.load) |=> $stable(t1.count))
    else $error("second timer moved while off");

  // second timer holds while the gate is closed
  chk_second_gate_hold: assert property ( // [RL6]
    @(posedge i_clock) disable iff (i_srst)
    (t1_on && t1_ge && !gate_open && !t1.load) |=> $stable(t1.count))
    else $error("second timer moved with gate closed");

  // first timer frozen during sleep
  chk_first_sleep_hold: assert property ( // [RL13]
    @(posedge i_clock) disable iff (i_srst)
    (i_sleep && !t0.load) |=> $stable(t0.count))
    else $error("first timer counted in sleep");

  // oscillator stays active through sleep while enabled
  chk_osc_sleep_run: assert property ( // [RL11]
    @(posedge i_clock) disable iff (i_srst)
    (i_sleep && sense_en && range_hi) |=> o_osc_active)
    else $error("oscillator stopped in sleep");

  // disabled unit selects no channel and drives nothing
  chk_disabled_quiet: assert property ( // [RL14]
    @(posedge i_clock) disable iff (i_srst)
    !sense_en |=> (!o_channel_enable && !o_osc_active && !o_current_drive && !o_reference_high))
    else $error("disabled unit still active");

  // reference range follows the range bit
  chk_ref_range: assert property ( // [RL15]
    @(posedge i_clock) disable iff (i_srst)
    sense_en |=> o_reference_high == $past(range_hi))
    else $error("reference range wrong");

  // code 00: noise mode in high range, off in low range
  chk_noise_mode: assert property ( // [RL16]
    @(posedge i_clock) disable iff (i_srst)
    (sense_en && cur_range == 2'b00) |=> (o_osc_active == $past(range_hi)) && !o_current_drive)
    else $error("idle current code misdecoded");

  // status bit read back shows the direction seen at the read
  chk_dir_status: assert property ( // [RL17]
    @(posedge i_clock) disable iff (i_srst)
    (i_rd && i_addr == cs_pkg::SENSE_CONTROL_OFS) |=> o_rd_data[1] == $past(osc_dir))
    else $error("direction status wrong");

  // an oscillator edge yields a single pulse
  chk_osc_once: assert property ( // [RL18]
    @(posedge i_clock) disable iff (i_srst)
    osc_rise |=> !osc_rise)
    else $error("oscillator edge counted twice");

endmodule : cs_sense_top
`default_nettype wire

/* File: rtl/cs_pkg.sv */
// package of the capacitive sense counter: register map, field positions, reset values, clock-source codes.
// assumes an 8-bit register port and one 25 MHz system clock.
package cs_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] SENSE_CONTROL_OFS = 4'h0;
  localparam logic [3:0] FIRST_TIMER_CFG_OFS = 4'h1;
  localparam logic [3:0] FIRST_TIMER_CNT_OFS = 4'h2;
  localparam logic [3:0] SECOND_TIMER_CONTROL_OFS = 4'h3;
  localparam logic [3:0] SECOND_TIMER_LO_OFS = 4'h4;
  localparam logic [3:0] SECOND_TIMER_HI_OFS = 4'h5;
  localparam logic [3:0] SENSE_STATUS_OFS = 4'h6;

  // sense_control fields
  localparam int SENSE_UNIT_ENABLE_BIT = 7;
  localparam int REFERENCE_RANGE_SELECT_BIT = 6;
  localparam int CURRENT_RANGE_LSB = 2;
  localparam int OSC_DIRECTION_STATUS_BIT = 1;
  localparam int FIRST_TIMER_SENSE_CLOCK_SELECT_BIT = 0;
  localparam logic [7:0] SENSE_CONTROL_RESET = 8'h00;

  // first timer configuration field
  localparam int FIRST_TIMER_CLOCK_SOURCE_BIT = 0;

  // second_timer_control fields
  localparam int SECOND_TIMER_ON_BIT = 0;
  localparam int SECOND_TIMER_GATE_ENABLE_BIT = 1;
  localparam int GATE_TOGGLE_MODE_BIT = 2;
  localparam int GATE_POLARITY_BIT = 3;
  localparam int SECOND_TIMER_CLOCK_SOURCE_LSB = 4;
  localparam logic [7:0] SECOND_TIMER_CONTROL_RESET = 8'h00;

  // status fields
  localparam int FIRST_TIMER_OVERFLOW_BIT = 0;
  localparam int GATE_LEVEL_BIT = 1;

  // second timer clock-source codes
  typedef enum logic [1:0] {
    CS_SRC_INSTR = 2'b00,
    CS_SRC_SYSTEM = 2'b01,
    CS_SRC_EXTERNAL = 2'b10,
    CS_SRC_SENSE_OSC = 2'b11
  } cs_clock_source_type;

  // current range code that means off (low range) or noise detection (high range)
  localparam logic [1:0] CURRENT_RANGE_IDLE = 2'b00;

  // counter wrap points
  localparam logic [15:0] FIRST_TIMER_WRAP = 16'h00ff;
  localparam logic [15:0] SECOND_TIMER_WRAP = 16'hffff;

  // instruction tick: system clock divided by four
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int INSTR_PERIOD_NS = 160;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_PERIOD_NS / CLOCK_PERIOD_NS - 1);

endpackage : cs_pkg

/* File: rtl/cs_count_if.sv */
// interface carrying one counter's increment, load and state.
// assumes both ends run on the single system clock.
`timescale 1ns/10ps
`default_nettype none
interface cs_count_if;
  logic inc;
  logic load;
  logic [15:0] load_val;
  logic [15:0] count;
  logic ovf;

  modport ctl (output inc, output load, output load_val, input count, input ovf);
  modport cnt (input inc, input load, input load_val, output count, output ovf);
endinterface : cs_count_if
`default_nettype wire

/* File: rtl/cs_sync.sv */
// two-flop synchroniser with a rising-edge pulse taken after the second flop.
// assumes the input changes slower than half the system clock.
`timescale 1ns/10ps
`default_nettype none
module cs_sync (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // asynchronous level
  input wire logic i_async,
  // synchronised level and edge
  output logic o_level,
  output logic o_rise
);
  logic meta_r;
  logic level_r;
  logic prev_r;

  // first flop feeds only the second
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      meta_r <= 1'b0;
      level_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= i_async;
      level_r <= meta_r;
      prev_r <= level_r;
    end
  end

  // one pulse per rising edge
  assign o_level = level_r;
  assign o_rise = level_r & ~prev_r;
endmodule : cs_sync
`default_nettype wire

/* File: rtl/cs_counter.sv */
// counter with load, increment and a one-cycle overflow pulse at its wrap point.
// assumes load and increment come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cs_counter #(
  parameter logic [15:0] WRAP = 16'hffff
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_srst,
  // control and state
  cs_count_if.cnt cnt
);
  logic [15:0] count_r;
  logic ovf_r;
  logic at_wrap;

  assign at_wrap = (count_r == WRAP);

  // load wins over increment
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      count_r <= 16'h0000;
      ovf_r <= 1'b0;
    end else if (cnt.load) begin
      count_r <= cnt.load_val & WRAP;
      ovf_r <= 1'b0;
    end else begin
      count_r <= cnt.inc ? (at_wrap ? 16'h0000 : 16'(count_r + 16'h0001)) : count_r;
      ovf_r <= cnt.inc & at_wrap;
    end
  end

  assign cnt.count = count_r;
  assign cnt.ovf = ovf_r;
endmodule : cs_counter
`default_nettype wire

/* File: tb/cs_osc_model.sv */
// sensing oscillator model: comparator level of a touch pad's triangle wave.
// assumes the bench gates it with run; between bursts the level stands still.
`timescale 1ns/10ps
`default_nettype none
module cs_osc_model (
  // clock
  input wire logic i_clock,
  // run gate and half period in clocks from the bench
  input wire logic i_run,
  input wire logic [3:0] i_half,
  // comparator level: 1 while sourcing, 0 while sinking
  output logic o_pin
);
  int cnt = 0;

  // flip the comparator every i_half clocks while running, whatever the sleep state
  initial o_pin = 1'b0;
  always @(posedge i_clock) begin
    if (!i_run) begin
      cnt <= 0;
    end else if (cnt == int'(i_half) - 1) begin
      cnt <= 0;
      o_pin <= ~o_pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : cs_osc_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the capacitive sense frequency counter.
// assumes the oscillator model at the sense pin and a 25 MHz system clock.
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int H = 3;
  logic i_clock, i_srst, i_wr, i_rd, i_sleep, i_gate_pin, osc_run, osc_pin;
  logic [3:0] i_addr;
  logic [3:0] half;
  logic [7:0] i_wr_data, o_rd_data;
  logic [15:0] rd_val;
  logic o_channel_enable, o_reference_high, o_osc_active, o_current_drive;
  logic [1:0] o_current_range;
  wire logic [15:0] analog;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  // analog controls packed as enable, range, code, active, drive
  assign analog = {10'h000, o_channel_enable, o_reference_high, o_current_range, o_osc_active, o_current_drive};

  cs_sense_top i_dut (
    .i_clock(i_clock), .i_srst(i_srst), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_sleep(i_sleep),
    .i_osc_pin(osc_pin), .i_gate_pin(i_gate_pin), .o_channel_enable(o_channel_enable),
    .o_reference_high(o_reference_high), .o_current_range(o_current_range),
    .o_osc_active(o_osc_active), .o_current_drive(o_current_drive)
  );

  cs_osc_model i_osc (.i_clock(i_clock), .i_run(osc_run), .i_half(half), .o_pin(osc_pin));

  // 40 ns system clock
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end

  // verdict and end of run
  task automatic tally_and_finish;
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rd_val = {8'h00, o_rd_data};
  endtask : rd

  // let the pad oscillate n full periods, then let the synchronisers drain
  task automatic pulses(input int n);
    @(posedge i_clock);
    osc_run <= 1'b1;
    repeat (2 * n * int'(half)) @(posedge i_clock);
    osc_run <= 1'b0;
    repeat (8) @(posedge i_clock);
  endtask : pulses

  task automatic t_reset;
    #1 check(analog, 16'h0000);
    rd(cs_pkg::SENSE_CONTROL_OFS);
    check(rd_val, {8'h00, cs_pkg::SENSE_CONTROL_RESET});
    rd(cs_pkg::FIRST_TIMER_CFG_OFS);
    check(rd_val, 16'h0001);
    rd(cs_pkg::SECOND_TIMER_CONTROL_OFS);
    check(rd_val, {8'h00, cs_pkg::SECOND_TIMER_CONTROL_RESET});
    wr(4'h9, 8'hff);
    rd(4'h9);
    check(rd_val, 16'h0000);
  endtask : t_reset

  // enable, range and code combinations against the analog controls and read-back
  task automatic t_analog;
    logic [7:0] cw [4] = '{8'h8d, 8'hc0, 8'h80, 8'h4c};
    logic [15:0] ex [4] = '{16'h002f, 16'h0032, 16'h0020, 16'h0000};
    for (int k = 0; k < 4; k++) begin
      wr(cs_pkg::SENSE_CONTROL_OFS, cw[k]);
      repeat (2) @(posedge i_clock);
      #1 check(analog, ex[k]);
      rd(cs_pkg::SENSE_CONTROL_OFS);
      check(rd_val, {8'h00, cw[k] & 8'hcd});
    end
  endtask : t_analog

  // first timer on the oscillator, direction bit, halt in sleep
  task automatic t_first;
    wr(cs_pkg::FIRST_TIMER_CFG_OFS, 8'h00);
    wr(cs_pkg::SENSE_CONTROL_OFS, 8'h8d);
    wr(cs_pkg::FIRST_TIMER_CNT_OFS, 8'h00);
    pulses(10);
    rd(cs_pkg::FIRST_TIMER_CNT_OFS);
    check(rd_val, 16'h000a);
    @(posedge i_clock);
    osc_run <= 1'b1;
    repeat (H) @(posedge i_clock);
    osc_run <= 1'b0;
    repeat (6) @(posedge i_clock);
    rd(cs_pkg::SENSE_CONTROL_OFS);
    check(rd_val, 16'h008f);
    i_sleep <= 1'b1;
    pulses(5);
    i_sleep <= 1'b0;
    rd(cs_pkg::FIRST_TIMER_CNT_OFS);
    check(rd_val, 16'h000b);
  endtask : t_first

  // second timer on the oscillator: sleep, off, gated, oscillator off
  task automatic t_second;
    wr(cs_pkg::FIRST_TIMER_CFG_OFS, 8'h01);
    wr(cs_pkg::SENSE_CONTROL_OFS, 8'h8c);
    wr(cs_pkg::SECOND_TIMER_CONTROL_OFS, 8'h31);
    wr(cs_pkg::SECOND_TIMER_LO_OFS, 8'h00);
    wr(cs_pkg::SECOND_TIMER_HI_OFS, 8'h00);
    i_sleep <= 1'b1;
    pulses(12);
    i_sleep <= 1'b0;
    rd(cs_pkg::SECOND_TIMER_LO_OFS);
    check(rd_val, 16'h000c);
    rd(cs_pkg::SECOND_TIMER_HI_OFS);
    check(rd_val, 16'h0000);
    wr(cs_pkg::SECOND_TIMER_CONTROL_OFS, 8'h30);
    pulses(5);
    rd(cs_pkg::SECOND_TIMER_LO_OFS);
    check(rd_val, 16'h000c);
    wr(cs_pkg::SECOND_TIMER_CONTROL_OFS, 8'h33);
    pulses(5);
    rd(cs_pkg::SECOND_TIMER_LO_OFS);
    check(rd_val, 16'h000c);
    i_gate_pin <= 1'b1;
    pulses(4);
    rd(cs_pkg::SECOND_TIMER_LO_OFS);
    check(rd_val, 16'h0010);
    for (int k = 0; k < 2; k++) begin
      wr(cs_pkg::SENSE_CONTROL_OFS, (k == 0) ? 8'h80 : 8'h0c);
      pulses(3);
      rd(cs_pkg::SECOND_TIMER_LO_OFS);
      check(rd_val, 16'h0010);
    end
  endtask : t_second

  // window timed by first timer overflows in toggle gate mode: baseline pad, then a slower loaded pad
  task automatic t_window;
    logic [15:0] got [2];
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock);
      half <= (k == 0) ? 4'd3 : 4'd5;
      wr(cs_pkg::SENSE_CONTROL_OFS, 8'h8c);
      wr(cs_pkg::FIRST_TIMER_CFG_OFS, 8'h00); // window on instruction ticks, not the oscillator
      wr(cs_pkg::SECOND_TIMER_CONTROL_OFS, 8'h37); // oscillator source, gated, toggle mode
      wr(cs_pkg::SECOND_TIMER_LO_OFS, 8'h00); // cleared at the window start
      wr(cs_pkg::SECOND_TIMER_HI_OFS, 8'h00);
      wr(cs_pkg::FIRST_TIMER_CNT_OFS, 8'hff);
      repeat (8) @(posedge i_clock);
      rd(cs_pkg::SENSE_STATUS_OFS);
      check(rd_val, 16'h0003); // window open, overflow flagged
      wr(cs_pkg::SENSE_STATUS_OFS, 8'h00);
      osc_run <= 1'b1;
      repeat (60) @(posedge i_clock);
      osc_run <= 1'b0;
      repeat (1100) @(posedge i_clock);
      rd(cs_pkg::SENSE_STATUS_OFS);
      check(rd_val, 16'h0001); // next overflow closed the window
      osc_run <= 1'b1;
      repeat (60) @(posedge i_clock);
      osc_run <= 1'b0;
      repeat (8) @(posedge i_clock);
      rd(cs_pkg::SECOND_TIMER_LO_OFS);
      got[k] = rd_val; // captured at the window end
    end
    check(got[0], 16'h000a); // ten six-clock periods in a sixty-clock burst
    check(got[1], 16'h0006); // same window, loaded pad
    check({15'h0000, got[1] < got[0]}, 16'h0001);
    check((got[0] + got[1]) >> 1, 16'h0008); // threshold midway
  endtask : t_window

  // reset, then the scenarios in order
  initial begin
    i_srst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wr_data = 8'h00;
    i_sleep = 1'b0;
    i_gate_pin = 1'b0;
    osc_run = 1'b0;
    half = 4'd3;
    repeat (12) @(posedge i_clock);
    i_srst <= 1'b0;
    t_reset();
    t_analog();
    t_first();
    t_second();
    t_window();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
